/* File: capture_frame_ctrl.v */
// frame level control of the sensor capture controller
`timescale 1ns/1ps
`include "capture_consts.vh"
module capture_frame_ctrl (
  // clock and reset
  input wire clock_in,
  input wire sys_rst_in,
  // register port
  input wire [3:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [31:0] reg_rdata_out,
  // sensor link pins
  input wire pixel_clock_in,
  input wire line_sync_in,
  input wire frame_sync_in,
  input wire field_id_in,
  input wire cam_gate_field_pin_in,
  output reg line_sync_out,
  output reg line_sync_oe_out,
  output reg frame_sync_out,
  output reg frame_sync_oe_out,
  // memory write path
  output reg mem_write_gate_out,
  output reg [31:0] mem_addr_out,
  output reg frame_start_out,
  // interrupts
  output reg line_irq_a_out,
  output reg line_irq_b_out,
  output reg field_write_irq_out
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  wire pclk_rise;
  wire hs_rise;
  wire vs_rise, vs_fall;
  wire fid_lvl;
  wire gate_lvl, gate_fall;
  // pixel clock, only its rising edge times the generator
  edge_sync u_pclk (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .async_in(pixel_clock_in),
    .level_out(),
    .rise_out(pclk_rise),
    .fall_out()
  );
  // external line sync, counted on its rising edge
  edge_sync u_hs (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .async_in(line_sync_in),
    .level_out(),
    .rise_out(hs_rise),
    .fall_out()
  );
  // external frame sync, both edges for the polarity choice
  edge_sync u_vs (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .async_in(frame_sync_in),
    .level_out(),
    .rise_out(vs_rise),
    .fall_out(vs_fall)
  );
  // field id level, read at each frame start
  edge_sync u_fid (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .async_in(field_id_in),
    .level_out(fid_lvl),
    .rise_out(),
    .fall_out()
  );
  // write gate pin, level gates writes and fall raises the irq
  edge_sync u_gate (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .async_in(cam_gate_field_pin_in),
    .level_out(gate_lvl),
    .rise_out(),
    .fall_out(gate_fall)
  );

  // ************************************************************
  // registers
  // ************************************************************
  reg frame_sync_enable_q;
  reg memory_write_enable_q;
  reg [4:0] mode_q;
  reg [1:0] config_q;
  reg [15:0] addr_high_q;
  reg [15:0] addr_low_q;
  reg [15:0] irq_cnt_a_q;
  reg [15:0] irq_cnt_b_q;
  reg [31:0] framing_a_q;
  reg [31:0] framing_b_q;
  reg [15:0] line_total_q;
  reg [15:0] pixel_total_q;
  // active copies of the selectable set
  reg act_write_enable_q;
  reg [31:0] act_addr_q;
  reg [31:0] act_framing_a_q;
  reg [31:0] act_framing_b_q;
  reg [15:0] act_line_total_q;
  reg [15:0] act_pixel_total_q;
  // frame state
  reg field_parity_q;
  reg capturing_q;
  reg [15:0] line_cnt_q;
  reg [15:0] gen_pix_q;
  reg [15:0] gen_line_q;

  wire latch_mode = config_q[`BIT_LATCH_MODE];
  wire sync_pol = mode_q[`BIT_SYNC_POL];
  wire ext_gate_en = mode_q[`BIT_EXT_GATE_EN];
  wire master_mode = mode_q[`BIT_MASTER];
  wire interlace = mode_q[`BIT_INTERLACE];
  wire enable_rise;
  reg enable_prev_q;
  assign enable_rise = frame_sync_enable_q & ~enable_prev_q;

  // master sync generator edges, timed by the pixel clock
  wire gen_line_end = pclk_rise & (gen_pix_q == act_pixel_total_q);
  wire gen_frame_end = gen_line_end & (gen_line_q == act_line_total_q);

  // selected frame start edge and line pulses
  wire ext_start = sync_pol ? vs_fall : vs_rise;
  wire frame_start = master_mode ? (enable_rise | gen_frame_end) : ext_start;
  wire line_pulse = master_mode ? gen_line_end : hs_rise;
  wire latch_evt = frame_sync_enable_q & frame_start;

  // software register writes
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      frame_sync_enable_q <= 1'b0;
      memory_write_enable_q <= 1'b0;
      mode_q <= 5'h00;
      config_q <= 2'h0;
      addr_high_q <= 16'h0000;
      addr_low_q <= 16'h0000;
      irq_cnt_a_q <= 16'h0000;
      irq_cnt_b_q <= 16'h0000;
      framing_a_q <= 32'h00000000;
      framing_b_q <= 32'h00000000;
      line_total_q <= `LINE_TOTAL_RST;
      pixel_total_q <= `PIXEL_TOTAL_RST;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `REG_SYNC_CTRL) begin
        frame_sync_enable_q <= reg_wdata_in[`BIT_FRAME_SYNC_EN];
        memory_write_enable_q <= reg_wdata_in[`BIT_MEM_WRITE_EN];
      end else if (reg_addr_in == `REG_MODE) begin
        mode_q <= reg_wdata_in[4:0];
      end else if (reg_addr_in == `REG_CONFIG) begin
        config_q <= reg_wdata_in[1:0];
      end else if (reg_addr_in == `REG_ADDR_HIGH) begin
        addr_high_q <= reg_wdata_in[15:0];
      end else if (reg_addr_in == `REG_ADDR_LOW) begin
        addr_low_q <= reg_wdata_in[15:0];
      end else if (reg_addr_in == `REG_LINE_IRQ) begin
        irq_cnt_a_q <= reg_wdata_in[15:0];
        irq_cnt_b_q <= reg_wdata_in[31:16];
      end else if (reg_addr_in == `REG_FRAMING_A) begin
        framing_a_q <= reg_wdata_in;
      end else if (reg_addr_in == `REG_FRAMING_B) begin
        framing_b_q <= reg_wdata_in;
      end else if (reg_addr_in == `REG_LINE_TOTAL) begin
        line_total_q <= reg_wdata_in[15:0];
        pixel_total_q <= reg_wdata_in[31:16];
      end
    end
  end

  // ************************************************************
  // shadow latching of the selectable set
  // ************************************************************
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      act_write_enable_q <= 1'b0;
      act_addr_q <= 32'h00000000;
      act_framing_a_q <= 32'h00000000;
      act_framing_b_q <= 32'h00000000;
      act_line_total_q <= `LINE_TOTAL_RST;
      act_pixel_total_q <= `PIXEL_TOTAL_RST;
    end else if (latch_mode | latch_evt) begin
      act_write_enable_q <= memory_write_enable_q;
      act_addr_q <= {addr_high_q, addr_low_q};
      act_framing_a_q <= framing_a_q;
      act_framing_b_q <= framing_b_q;
      act_line_total_q <= line_total_q;
      act_pixel_total_q <= pixel_total_q;
    end
  end

  // ************************************************************
  // frame state and master sync generator
  // ************************************************************
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      enable_prev_q <= 1'b0;
      capturing_q <= 1'b0;
      field_parity_q <= 1'b0;
      line_cnt_q <= 16'h0000;
      gen_pix_q <= 16'h0000;
      gen_line_q <= 16'h0000;
    end else begin
      enable_prev_q <= frame_sync_enable_q;
      if (!frame_sync_enable_q) begin
        capturing_q <= 1'b0;
        line_cnt_q <= 16'h0000;
        gen_pix_q <= 16'h0000;
        gen_line_q <= 16'h0000;
      end else begin
        if (frame_start) begin
          capturing_q <= 1'b1;
          line_cnt_q <= 16'h0000;
        end else if (line_pulse && line_cnt_q != 16'hFFFF) begin
          line_cnt_q <= line_cnt_q + 16'h0001;
        end
        if (pclk_rise) begin
          if (gen_line_end) begin
            gen_pix_q <= 16'h0000;
            gen_line_q <= gen_frame_end ? 16'h0000 : gen_line_q + 16'h0001;
          end else begin
            gen_pix_q <= gen_pix_q + 16'h0001;
          end
        end
      end
      // parity takes the inverted field id when interlaced, else toggles per field
      if (frame_sync_enable_q && frame_start) begin
        field_parity_q <= interlace ? ~fid_lvl : ~field_parity_q;
      end
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      line_sync_out <= 1'b0;
      line_sync_oe_out <= 1'b0;
      frame_sync_out <= 1'b0;
      frame_sync_oe_out <= 1'b0;
      mem_write_gate_out <= 1'b0;
      mem_addr_out <= 32'h00000000;
      frame_start_out <= 1'b0;
      line_irq_a_out <= 1'b0;
      line_irq_b_out <= 1'b0;
      field_write_irq_out <= 1'b0;
    end else begin
      line_sync_oe_out <= master_mode;
      frame_sync_oe_out <= master_mode;
      line_sync_out <= master_mode & frame_sync_enable_q & (gen_pix_q == 16'h0000);
      frame_sync_out <= master_mode & frame_sync_enable_q & (gen_line_q == 16'h0000);
      mem_write_gate_out <= frame_sync_enable_q & capturing_q & act_write_enable_q &
        (~ext_gate_en | gate_lvl);
      mem_addr_out <= act_addr_q;
      frame_start_out <= latch_evt;
      // line count interrupts, pulses only while enabled
      line_irq_a_out <= frame_sync_enable_q & capturing_q & line_pulse &
        (line_cnt_q + 16'h0001 == irq_cnt_a_q);
      line_irq_b_out <= frame_sync_enable_q & capturing_q & line_pulse &
        (line_cnt_q + 16'h0001 == irq_cnt_b_q);
      field_write_irq_out <= frame_sync_enable_q & ext_gate_en & gate_fall;
    end
  end

  // read data one cycle after the strobe
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (reg_rd_in) begin
      if (reg_addr_in == `REG_SYNC_CTRL) begin
        reg_rdata_out <= {30'h0, memory_write_enable_q, frame_sync_enable_q};
      end else if (reg_addr_in == `REG_MODE) begin
        reg_rdata_out <= {27'h0, mode_q};
      end else if (reg_addr_in == `REG_CONFIG) begin
        reg_rdata_out <= {30'h0, config_q};
      end else if (reg_addr_in == `REG_ADDR_HIGH) begin
        reg_rdata_out <= {16'h0, addr_high_q};
      end else if (reg_addr_in == `REG_ADDR_LOW) begin
        reg_rdata_out <= {16'h0, addr_low_q};
      end else if (reg_addr_in == `REG_LINE_IRQ) begin
        reg_rdata_out <= {irq_cnt_b_q, irq_cnt_a_q};
      end else if (reg_addr_in == `REG_STATUS) begin
        reg_rdata_out <= {29'h0, act_write_enable_q, capturing_q, field_parity_q};
      end else if (reg_addr_in == `REG_FRAMING_A) begin
        reg_rdata_out <= framing_a_q;
      end else if (reg_addr_in == `REG_FRAMING_B) begin
        reg_rdata_out <= framing_b_q;
      end else if (reg_addr_in == `REG_LINE_TOTAL) begin
        reg_rdata_out <= {pixel_total_q, line_total_q};
      end else begin
        reg_rdata_out <= 32'h00000000;
      end
    end else begin
      reg_rdata_out <= 32'h00000000;
    end
  end
endmodule

/* File: capture_consts.vh */
// constants for the sensor capture frame control block
// Behaviour
// - operate only while frame_sync_enable is set (sync oe outputs follow master mode regardless)
// - early enable keeps previously held address
// - capture frames continuously until enable cleared
// - clearing enable aborts current frame at once
// - master mode starts frame immediately on enable
// - slave mode follows external syncs, waits data
// - three interrupts, only while enabled
// - line interrupt after programmed line count
// - polarity picks frame sync start edge
// - embedded sync gives frame sync per field (BIT_EMBEDDED is stored in the mode register but unused)
// - field irq on pin fall, both enables
// - parity flag set on even field
// - shadow reads latest write, applies on latch
// - latch mode selects shadowed or immediate
// - selectable set includes write enable, address
`ifndef CAPTURE_CONSTS_VH
`define CAPTURE_CONSTS_VH
// register offsets
`define REG_SYNC_CTRL 4'h0
`define REG_MODE 4'h1
`define REG_CONFIG 4'h2
`define REG_ADDR_HIGH 4'h3
`define REG_ADDR_LOW 4'h4
`define REG_LINE_IRQ 4'h5
`define REG_STATUS 4'h6
`define REG_FRAMING_A 4'h7
`define REG_FRAMING_B 4'h8
`define REG_LINE_TOTAL 4'h9
// sync control fields
`define BIT_FRAME_SYNC_EN 0
`define BIT_MEM_WRITE_EN 1
// mode fields
`define BIT_SYNC_POL 0
`define BIT_EXT_GATE_EN 1
`define BIT_MASTER 2
`define BIT_EMBEDDED 3
`define BIT_INTERLACE 4
// config fields
`define BIT_LATCH_MODE 0
`define BIT_YC_SWAP 1
// status fields
`define BIT_FIELD_PARITY 0
`define BIT_CAPTURING 1
`define BIT_WRITE_ACTIVE 2
// master sync generator reset totals
`define LINE_TOTAL_RST 16'h0010
`define PIXEL_TOTAL_RST 16'h0020
`endif

/* File: edge_sync.v */
// two flop synchroniser with edge detection
`timescale 1ns/1ps
module edge_sync (
  // clock and reset
  input wire clock_in,
  input wire sys_rst_in,
  // asynchronous level
  input wire async_in,
  // synchronised level and edges
  output reg level_out,
  output reg rise_out,
  output reg fall_out
);
  reg meta_q;
  reg sync_q;
  // first flop feeds only the second
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      level_out <= 1'b0;
      rise_out <= 1'b0;
      fall_out <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      level_out <= sync_q;
      rise_out <= sync_q & ~level_out;
      fall_out <= ~sync_q & level_out;
    end
  end
endmodule

/* File: capture_frame_ctrl_checker.sv */
// assertions on the capture_frame_ctrl ports
`timescale 1ns/1ps
module capture_frame_ctrl_checker (
  // clock and reset
  input wire clock_in,
  input wire sys_rst_in,
  // register port
  input wire [3:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  // pins and outputs
  input wire cam_gate_field_pin_in,
  input wire line_sync_oe_out,
  input wire frame_sync_oe_out,
  input wire mem_write_gate_out,
  input wire [31:0] mem_addr_out,
  input wire frame_start_out,
  input wire line_irq_a_out,
  input wire line_irq_b_out,
  input wire field_write_irq_out
);
  // ****
  // control bits seen on the register port
  // ****
  reg en_q, xg_q, ms_q, lm_q;
  reg [15:0] lo_q;
  reg [1:0] fsp_q;
  reg [3:0] low_q;
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      en_q <= 1'b0;
      xg_q <= 1'b0;
      ms_q <= 1'b0;
      lm_q <= 1'b0;
      lo_q <= 16'h0000;
      fsp_q <= 2'h0;
    end else begin
      fsp_q <= {fsp_q[0], frame_start_out};
      if (reg_wr_in && reg_addr_in == 4'h0) en_q <= reg_wdata_in[0];
      if (reg_wr_in && reg_addr_in == 4'h1) xg_q <= reg_wdata_in[1];
      if (reg_wr_in && reg_addr_in == 4'h1) ms_q <= reg_wdata_in[2];
      if (reg_wr_in && reg_addr_in == 4'h2) lm_q <= reg_wdata_in[0];
      if (reg_wr_in && reg_addr_in == 4'h4) lo_q <= reg_wdata_in[15:0];
    end
  end
  // cycles the gate pin has been low, saturating
  always @(posedge clock_in) begin
    if (sys_rst_in || cam_gate_field_pin_in) low_q <= 4'h0;
    else if (low_q != 4'hF) low_q <= low_q + 4'h1;
  end
  // ****
  // assertions
  // ****
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  sequence master_go;
    $rose(en_q) && ms_q;
  endsequence
  sequence enable_dropped;
    $fell(en_q);
  endsequence
  a_master_start: assert property (master_go |-> ##[0:3] frame_start_out)
    else $error("no frame start after master enable");
  a_irq_a_enable: assert property (line_irq_a_out |-> $past(en_q))
    else $error("line irq a while disabled");
  a_irq_b_enable: assert property (line_irq_b_out |-> $past(en_q))
    else $error("line irq b while disabled");
  a_field_irq_enable: assert property (field_write_irq_out |-> $past(en_q) && $past(xg_q))
    else $error("field irq without both enables");
  a_field_irq_delay: assert property (field_write_irq_out |->
    low_q >= 4'h2 && low_q <= 4'h7)
    else $error("field irq not tied to a pin fall");
  a_gate_needs_enable: assert property (mem_write_gate_out |-> $past(en_q))
    else $error("write gate open while disabled");
  a_abort_now: assert property (enable_dropped |=> !mem_write_gate_out && !frame_start_out)
    else $error("capture continued after disable");
  a_oe_mode: assert property (ms_q == $past(ms_q, 2) |->
    line_sync_oe_out == ms_q && frame_sync_oe_out == ms_q)
    else $error("sync drive does not follow mode");
  a_addr_latch: assert property (!lm_q && $changed(mem_addr_out) |->
    frame_start_out || fsp_q != 2'h0)
    else $error("address changed outside frame start");
  a_addr_immediate: assert property (lm_q && $past(lm_q, 4) && lo_q == $past(lo_q, 3) |->
    mem_addr_out[15:0] == lo_q)
    else $error("address not applied at once");
endmodule
bind capture_frame_ctrl capture_frame_ctrl_checker capture_frame_ctrl_checker_inst (
  .clock_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .cam_gate_field_pin_in,
  .line_sync_oe_out, .frame_sync_oe_out, .mem_write_gate_out, .mem_addr_out,
  .frame_start_out, .line_irq_a_out, .line_irq_b_out, .field_write_irq_out);

/* File: sensor_model.sv */
// behavioural model of the external sensor driving the link pins
`timescale 1ns/1ps
module sensor_model (
  // control
  input wire run_in,
  // link pins
  output reg pclk_out,
  output reg line_out,
  output reg frame_out,
  output reg field_out,
  output reg gate_out
);
  // ****
  // pixel clock, still between frames
  // ****
  task tick(input integer n);
    begin
      repeat (n) begin
        #400 pclk_out = 1'b1;
        #400 pclk_out = 1'b0;
      end
    end
  endtask
  // frame sync pulse, then eight lines under the write gate
  initial begin
    pclk_out = 1'b0;
    line_out = 1'b0;
    frame_out = 1'b0;
    field_out = 1'b0;
    gate_out = 1'b0;
    #137;
    forever begin
      wait (run_in);
      frame_out = 1'b1;
      tick(1);
      frame_out = 1'b0;
      tick(1);
      gate_out = 1'b1;
      repeat (8) begin
        line_out = 1'b1;
        tick(1);
        line_out = 1'b0;
        tick(3);
      end
      gate_out = 1'b0;
      field_out = !field_out;
      #20000;
    end
  end
endmodule

/* File: capture_frame_ctrl_bench.sv */
// self-checking bench for capture_frame_ctrl
`timescale 1ns/1ps
module capture_frame_ctrl_bench;
  // ****
  // stimulus, monitors and tests
  // ****
  reg clock_in, sys_rst_in, reg_wr_in, reg_rd_in, run, pol, ms, p;
  reg [3:0] reg_addr_in;
  reg [31:0] reg_wdata_in, v;
  wire [31:0] reg_rdata_out, mem_addr_out;
  wire pclk, ls, fs, field_id, gate, ls_oe, wg, fst, ia, ib, fi, lso, fso;
  integer n_errors, cmp_count, ca, cb, cf, cs, nl;
  time t_rise;
  capture_frame_ctrl capture_frame_ctrl_inst (.clock_in, .sys_rst_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .pixel_clock_in(pclk),
    .line_sync_in(ls), .frame_sync_in(fs), .field_id_in(field_id), .cam_gate_field_pin_in(gate),
    .line_sync_out(lso), .line_sync_oe_out(ls_oe), .frame_sync_out(fso), .frame_sync_oe_out(),
    .mem_write_gate_out(wg), .mem_addr_out, .frame_start_out(fst), .line_irq_a_out(ia),
    .line_irq_b_out(ib), .field_write_irq_out(fi));
  sensor_model sensor_model_inst (.run_in(run), .pclk_out(pclk), .line_out(ls),
    .frame_out(fs), .field_out(field_id), .gate_out(gate));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge clock_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clock_in);
      reg_wr_in <= 1'b0;
    end
  endtask
  task rd(input [3:0] a);
    begin
      @(posedge clock_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clock_in);
      reg_rd_in <= 1'b0;
      #1 v = reg_rdata_out;
    end
  endtask
  task wait_start;
    integer i;
    begin
      i = 0;
      @(posedge clock_in);
      #1 while (fst !== 1'b1 && i < 2000) begin
        @(posedge clock_in);
        #1 i = i + 1;
      end
      chk(fst, 32'h1);
      repeat (2) @(posedge clock_in);
    end
  endtask
  task clr;
    begin
      ca = 0;
      cb = 0;
      cf = 0;
      cs = 0;
    end
  endtask
  task conclude;
    begin
      if (n_errors == 0 && cmp_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // clock and watchdog
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  initial begin
    #2000000;
    $display("CHECK FAILED at %0t: timeout", $time);
    n_errors = n_errors + 1;
    conclude;
  end
  // event counters and line position checks
  always @(posedge fs) t_rise = $time;
  always @(posedge ls) nl = nl + 1;
  always @(posedge clock_in) begin
    ca = ca + ia;
    cb = cb + ib;
    cf = cf + fi;
    cs = cs + fst;
    if (fst) nl = 0;
    if (ia) chk(nl, 32'h3);
    if (ib) chk(nl, 32'h5);
    if (fst && !ms) chk($time - t_rise >= 800, pol);
  end
  // test sequence
  initial begin
    sys_rst_in = 1'b1;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 4'h0;
    reg_wdata_in = 32'h0;
    run = 1'b0;
    pol = 1'b0;
    ms = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    nl = 0;
    t_rise = 0;
    repeat (5) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    clr;
    rd(4'h9);
    chk(v, 32'h00200010);
    rd(4'hF);
    chk(v, 32'h0);
    wr(4'h5, 32'h00050003);
    wr(4'h3, 32'h00000012);
    wr(4'h4, 32'h00003400);
    wr(4'h1, 32'h00000002);
    rd(4'h4);
    chk(v, 32'h00003400);
    run <= 1'b1;
    repeat (1000) @(posedge clock_in);
    chk(ca + cb + cf + cs, 32'h0);
    chk(mem_addr_out, 32'h0);
    chk({lso, fso}, 32'h0);
    wr(4'h7, 32'h00100020);
    wr(4'h8, 32'h00080004);
    rd(4'h7);
    chk(v, 32'h00100020);
    wr(4'h0, 32'h00000003);
    wait_start;
    repeat (30) @(posedge clock_in);
    chk(mem_addr_out, 32'h00123400);
    chk(wg, 32'h1);
    wr(4'h4, 32'h00005600);
    chk(mem_addr_out, 32'h00123400);
    clr;
    wait_start;
    chk(mem_addr_out, 32'h00125600);
    rd(4'h6);
    p = v[0];
    wait_start;
    chk(ca * 100 + cb * 10 + cf, 32'd222);
    rd(4'h6);
    chk(v[0], !p);
    pol = 1'b1;
    wr(4'h1, 32'h00000003);
    wait_start;
    wr(4'h1, 32'h00000011);
    clr;
    wait_start;
    rd(4'h6);
    chk(v[0], !field_id);
    chk(cf, 32'h0);
    repeat (90) @(posedge clock_in);
    wr(4'h0, 32'h00000000);
    wr(4'h7, 32'h00000000);
    wr(4'h8, 32'h00000000);
    clr;
    repeat (1000) @(posedge clock_in);
    chk(ca + cb + cf + cs, 32'h0);
    run <= 1'b0;
    ms = 1'b1;
    wr(4'h1, 32'h00000004);
    wr(4'h0, 32'h00000001);
    wait_start;
    chk(ls_oe, 32'h1);
    chk(fso, 32'h1);
    wr(4'h4, 32'h00007000);
    repeat (4) @(posedge clock_in);
    chk(mem_addr_out, 32'h00125600);
    wr(4'h2, 32'h00000001);
    wr(4'h4, 32'h00007800);
    repeat (8) @(posedge clock_in);
    chk(mem_addr_out, 32'h00127800);
    conclude;
  end
endmodule
